// ===== verilog/flash_status_host.sv
// Host controller end: issues bypass command sequences and polls toggle status
`timescale 1ns/1ns
`include "flash_map.svh"
module flash_status_host #(
  parameter int ADDR_W = `ADDR_W_DEF
) (
  input  logic                          clock,
  input  logic                          resetn,
  flash_link_if.host_end                link,
  input  logic                          req_valid,
  input  flash_types_pkg::host_kind_type req_kind,
  input  logic [ADDR_W-1:0]             req_addr,
  input  logic [15:0]                   req_data,
  output logic                          req_ready,
  output logic                          done,
  output logic [15:0]                   result
);
  import flash_types_pkg::*;

  host_state_type    hs_q;
  host_state_type    hs_d;
  host_kind_type     kind_q;
  host_kind_type     kind_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [ADDR_W-1:0] pin_addr_q;
  logic [ADDR_W-1:0] pin_addr_d;
  logic [15:0]       data_q;
  logic [15:0]       data_d;
  logic [15:0]       pin_wdata_q;
  logic [15:0]       pin_wdata_d;
  logic [15:0]       result_q;
  logic [15:0]       result_d;
  logic [1:0]        idx_q;
  logic [1:0]        idx_d;
  logic [1:0]        phase_q;
  logic [1:0]        phase_d;
  logic              cyc_q;
  logic              cyc_d;
  logic              prev6_q;
  logic              prev6_d;
  logic              ce_n_q;
  logic              ce_n_d;
  logic              oe_n_q;
  logic              oe_n_d;
  logic              we_n_q;
  logic              we_n_d;
  logic              ready_q;
  logic              ready_d;
  logic              done_q;
  logic              done_d;

  // ****************************************************************
  // Command sequences
  // ****************************************************************
  function automatic logic [1:0] seq_len(input host_kind_type k);
    case (k)
      K_ENTER:                                      return 2'h3;
      K_PROGRAM, K_SECTOR_ERASE, K_CHIP_ERASE, K_EXIT: return 2'h2;
      K_SUSPEND, K_RESUME:                          return 2'h1;
      default:                                      return 2'h0;
    endcase
  endfunction

  function automatic logic [ADDR_W+15:0] seq_word(input host_kind_type k, input logic [1:0] i,
                                                  input logic [ADDR_W-1:0] a, input logic [15:0] d);
    logic first;
    first = i == 2'h0;
    case (k)
      K_ENTER: begin
        if (i == 2'h0) return {ADDR_W'(`UNLOCK_ADDR_A), `CODE_UNLOCK_A};
        else if (i == 2'h1) return {ADDR_W'(`UNLOCK_ADDR_B), `CODE_UNLOCK_B};
        else return {ADDR_W'(`UNLOCK_ADDR_A), `CODE_BYPASS};
      end
      K_PROGRAM:      return {a, first ? `CODE_PROG_SETUP : d};
      K_SECTOR_ERASE: return {a, first ? `CODE_ERASE_SETUP : `CODE_SECTOR_ERASE};
      K_CHIP_ERASE:   return {a, first ? `CODE_ERASE_SETUP : `CODE_CHIP_ERASE};
      K_SUSPEND:      return {a, `CODE_SUSPEND};
      K_RESUME:       return {a, `CODE_RESUME};
      K_EXIT:         return {a, first ? `CODE_EXIT_A : `CODE_EXIT_B};
      default:        return {a, d};
    endcase
  endfunction

  wire [1:0] idx_inc = 2'(idx_q + 2'h1);
  wire       last_wr = idx_inc == seq_len(kind_q);
  wire       bit6    = link.rdata[6];

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    hs_d        = hs_q;
    kind_d      = kind_q;
    addr_d      = addr_q;
    data_d      = data_q;
    pin_addr_d  = pin_addr_q;
    pin_wdata_d = pin_wdata_q;
    result_d    = result_q;
    idx_d       = idx_q;
    phase_d     = phase_q;
    cyc_d       = cyc_q;
    prev6_d     = prev6_q;
    ce_n_d      = ce_n_q;
    oe_n_d      = oe_n_q;
    we_n_d      = we_n_q;
    ready_d     = ready_q;
    done_d      = 1'b0;
    case (hs_q)
      H_IDLE: begin
        if (req_valid && ready_q) begin
          kind_d  = req_kind;
          addr_d  = req_addr;
          data_d  = req_data;
          ready_d = 1'b0;
          idx_d   = 2'h0;
          phase_d = 2'h0;
          ce_n_d  = 1'b0;
          if (seq_len(req_kind) != 2'h0) begin
            hs_d                      = H_WR_LOW;
            {pin_addr_d, pin_wdata_d} = seq_word(req_kind, 2'h0, req_addr, req_data);
            we_n_d                    = 1'b0;
          end else begin
            hs_d       = H_RD_LOW;
            pin_addr_d = req_addr;
            oe_n_d     = 1'b0;
            cyc_d      = 1'b0;
          end
        end
      end
      H_WR_LOW: begin
        hs_d   = H_WR_HIGH;
        we_n_d = 1'b1;
      end
      H_WR_HIGH: begin
        if (last_wr) begin
          hs_d    = H_IDLE;
          ce_n_d  = 1'b1;
          ready_d = 1'b1;
          done_d  = 1'b1;
        end else begin
          hs_d                      = H_WR_LOW;
          idx_d                     = idx_inc;
          {pin_addr_d, pin_wdata_d} = seq_word(kind_q, idx_inc, addr_q, data_q);
          we_n_d                    = 1'b0;
        end
      end
      H_RD_LOW: begin
        if (!cyc_q) begin
          cyc_d = 1'b1;
        end else begin
          hs_d   = H_RD_HIGH;
          oe_n_d = 1'b1;
          ce_n_d = 1'b1;
          if (kind_q != K_POLL || phase_q == 2'h2) begin
            result_d = link.rdata;
            phase_d  = 2'h3;
          end else if (phase_q == 2'h0 || bit6 != prev6_q) begin
            prev6_d = bit6;
            phase_d = 2'h1;
          end else begin
            // Toggle stopped: one more read gives settled array data
            phase_d = 2'h2;
          end
        end
      end
      H_RD_HIGH: begin
        if (phase_q == 2'h3) begin
          hs_d    = H_IDLE;
          ready_d = 1'b1;
          done_d  = 1'b1;
        end else begin
          hs_d   = H_RD_LOW;
          ce_n_d = 1'b0;
          oe_n_d = 1'b0;
          cyc_d  = 1'b0;
        end
      end
      default: hs_d = H_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hs_q        <= H_IDLE;
      kind_q      <= K_READ;
      addr_q      <= '0;
      data_q      <= 16'h0000;
      pin_addr_q  <= '0;
      pin_wdata_q <= 16'h0000;
      result_q    <= 16'h0000;
      idx_q       <= 2'h0;
      phase_q     <= 2'h0;
      cyc_q       <= 1'b0;
      prev6_q     <= 1'b0;
      ce_n_q      <= 1'b1;
      oe_n_q      <= 1'b1;
      we_n_q      <= 1'b1;
      ready_q     <= 1'b1;
      done_q      <= 1'b0;
    end else begin
      hs_q        <= hs_d;
      kind_q      <= kind_d;
      addr_q      <= addr_d;
      data_q      <= data_d;
      pin_addr_q  <= pin_addr_d;
      pin_wdata_q <= pin_wdata_d;
      result_q    <= result_d;
      idx_q       <= idx_d;
      phase_q     <= phase_d;
      cyc_q       <= cyc_d;
      prev6_q     <= prev6_d;
      ce_n_q      <= ce_n_d;
      oe_n_q      <= oe_n_d;
      we_n_q      <= we_n_d;
      ready_q     <= ready_d;
      done_q      <= done_d;
    end
  end

  assign link.ce_n  = ce_n_q;
  assign link.oe_n  = oe_n_q;
  assign link.we_n  = we_n_q;
  assign link.addr  = pin_addr_q;
  assign link.wdata = pin_wdata_q;
  assign req_ready  = ready_q;
  assign done       = done_q;
  assign result     = result_q;
endmodule

// ===== verilog/flash_map.svh
// Constants for the flash status link: command codes, unlock addresses, timing figures
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH

`define CLK_PERIOD_NS      8
`define ADDR_W_DEF         12
`define SECT_W_DEF         3
`define DATA_W             16

`define UNLOCK_ADDR_A      12'h555
`define UNLOCK_ADDR_B      12'h2aa

`define CODE_UNLOCK_A      16'h00aa
`define CODE_UNLOCK_B      16'h0055
`define CODE_BYPASS        16'h0020
`define CODE_PROG_SETUP    16'h00a0
`define CODE_ERASE_SETUP   16'h0080
`define CODE_SECTOR_ERASE  16'h0030
`define CODE_CHIP_ERASE    16'h0010
`define CODE_SUSPEND       16'h00b0
`define CODE_RESUME        16'h0030
`define CODE_EXIT_A        16'h0090
`define CODE_EXIT_B        16'h0000

`define PROG_TIME_NS       400
`define PROTECTED_PROGRAM_STATUS_TIME_NS 800
`define PROTECTED_ERASE_STATUS_TIME_NS   800
`define ERASE_WINDOW_NS    400

`endif

// ===== verilog/flash_types_pkg.sv
// Types shared by both ends of the flash status link
package flash_types_pkg;

  typedef enum logic [2:0] {
    CMD_READ        = 3'b000,
    CMD_UNLOCK1     = 3'b001,
    CMD_UNLOCK2     = 3'b010,
    CMD_BYPASS      = 3'b011,
    CMD_PROG_SETUP  = 3'b100,
    CMD_ERASE_SETUP = 3'b101,
    CMD_EXIT_SETUP  = 3'b110
  } cmd_state_type;

  typedef enum logic [2:0] {
    OP_IDLE       = 3'b000,
    OP_PROGRAM    = 3'b001,
    OP_PROT_PROG  = 3'b010,
    OP_ERASE_WAIT = 3'b011,
    OP_ERASE      = 3'b100,
    OP_PROT_ERASE = 3'b101,
    OP_SUSPEND    = 3'b110,
    OP_SUSP_PROG  = 3'b111
  } op_state_type;

  typedef enum logic [3:0] {
    K_ENTER        = 4'h0,
    K_PROGRAM      = 4'h1,
    K_SECTOR_ERASE = 4'h2,
    K_CHIP_ERASE   = 4'h3,
    K_SUSPEND      = 4'h4,
    K_RESUME       = 4'h5,
    K_EXIT         = 4'h6,
    K_READ         = 4'h7,
    K_POLL         = 4'h8
  } host_kind_type;

  typedef enum logic [2:0] {
    H_IDLE    = 3'b000,
    H_WR_LOW  = 3'b001,
    H_WR_HIGH = 3'b010,
    H_RD_LOW  = 3'b011,
    H_RD_HIGH = 3'b100
  } host_state_type;

endpackage

// ===== verilog/flash_link_if.sv
// Interface joining the host controller and the flash device ends
`timescale 1ns/1ns
`include "flash_map.svh"
interface flash_link_if #(
  parameter int ADDR_W = `ADDR_W_DEF
) ();
  logic              ce_n;
  logic              oe_n;
  logic              we_n;
  logic [ADDR_W-1:0] addr;
  logic [15:0]       wdata;
  logic [15:0]       rdata;

  modport device_end (input ce_n, input oe_n, input we_n, input addr, input wdata, output rdata);
  modport host_end   (output ce_n, output oe_n, output we_n, output addr, output wdata, input rdata);
endinterface

// ===== verilog/flash_status_device.sv
// Flash device end: bypass command decoding, embedded program/erase and status reporting
`timescale 1ns/1ns
`include "flash_map.svh"

module flash_status_device #(
  parameter int ADDR_W     = `ADDR_W_DEF,
  parameter int SECT_W     = `SECT_W_DEF,
  parameter int PROG_CYC   = (`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int PSP_CYC    = (`PROTECTED_PROGRAM_STATUS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int ASP_CYC    = (`PROTECTED_ERASE_STATUS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int WINDOW_CYC = (`ERASE_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  logic                         clock,
  input  logic                         resetn,
  flash_link_if.device_end             link,
  input  logic [(1<<SECT_W)-1:0]       sector_protect,
  output logic                         busy,
  output logic                         bypass_mode,
  output flash_types_pkg::op_state_type op_state
);
  import flash_types_pkg::*;

  localparam int NSECT = 1 << SECT_W;
  localparam int DEPTH = 1 << ADDR_W;

  // ****************************************************************
  // Storage and state
  // ****************************************************************
  logic [15:0]       mem [DEPTH];
  cmd_state_type     cmd_q;
  cmd_state_type     cmd_d;
  op_state_type      op_q;
  op_state_type      op_d;
  logic [ADDR_W-1:0] paddr_q;
  logic [ADDR_W-1:0] paddr_d;
  logic [ADDR_W-1:0] walk_q;
  logic [ADDR_W-1:0] walk_d;
  logic [15:0]       pdata_q;
  logic [15:0]       pdata_d;
  logic [15:0]       rdata_q;
  logic [NSECT-1:0]  esel_q;
  logic [NSECT-1:0]  esel_d;
  logic [15:0]       cnt_q;
  logic [15:0]       cnt_d;
  logic              wr_prev_q;
  logic              rd_prev_q;
  logic              tog_q;
  logic              etog_q;
  logic              busy_q;
  logic              bypass_q;

  function automatic logic [SECT_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1 -: SECT_W];
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // A write is taken on the rising edge of the write strobe
  wire              write_take = wr_prev_q & link.we_n;
  wire              reading    = ~link.ce_n & ~link.oe_n;
  wire              read_start = reading & ~rd_prev_q;
  wire [SECT_W-1:0] sect       = sector_of(link.addr);
  wire [15:0]       wd         = link.wdata;
  wire              hit_a      = link.addr == ADDR_W'(`UNLOCK_ADDR_A);
  wire              hit_b      = link.addr == ADDR_W'(`UNLOCK_ADDR_B);
  wire              cnt_zero   = cnt_q == 16'h0000;
  wire              walk_last  = &walk_q;
  wire              wd_chip    = wd == `CODE_CHIP_ERASE;

  wire prog_go   = write_take && cmd_q == CMD_PROG_SETUP &&
                   (op_q == OP_IDLE || (op_q == OP_SUSPEND && !esel_q[sect] && !sector_protect[sect]));
  wire erase_go  = write_take && cmd_q == CMD_ERASE_SETUP && (wd == `CODE_SECTOR_ERASE || wd_chip) &&
                   (op_q == OP_IDLE || op_q == OP_ERASE_WAIT);
  wire susp_go   = write_take && cmd_q == CMD_BYPASS && wd == `CODE_SUSPEND && op_q == OP_ERASE;
  wire resume_go = write_take && cmd_q == CMD_BYPASS && wd == `CODE_RESUME && op_q == OP_SUSPEND;
  // Protected sectors never join the erase set
  wire [NSECT-1:0] erase_pick = wd_chip ? ~sector_protect : (~sector_protect & (NSECT'(1) << sect));

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always_comb begin
    cmd_d = cmd_q;
    if (write_take) begin
      case (cmd_q)
        CMD_READ:        cmd_d = (hit_a && wd == `CODE_UNLOCK_A) ? CMD_UNLOCK1 : CMD_READ;
        CMD_UNLOCK1:     cmd_d = (hit_b && wd == `CODE_UNLOCK_B) ? CMD_UNLOCK2 : CMD_READ;
        CMD_UNLOCK2:     cmd_d = (hit_a && wd == `CODE_BYPASS) ? CMD_BYPASS : CMD_READ;
        CMD_BYPASS: begin
          // Anything but the bypass commands is dropped here
          if (wd == `CODE_PROG_SETUP) cmd_d = CMD_PROG_SETUP;
          else if (wd == `CODE_ERASE_SETUP) cmd_d = CMD_ERASE_SETUP;
          else if (wd == `CODE_EXIT_A) cmd_d = CMD_EXIT_SETUP;
          else cmd_d = CMD_BYPASS;
        end
        CMD_PROG_SETUP:  cmd_d = CMD_BYPASS;
        CMD_ERASE_SETUP: cmd_d = CMD_BYPASS;
        CMD_EXIT_SETUP:  cmd_d = (wd == `CODE_EXIT_B) ? CMD_READ : CMD_BYPASS;
        default:         cmd_d = CMD_READ;
      endcase
    end
  end

  // ****************************************************************
  // Embedded algorithm
  // ****************************************************************
  always_comb begin
    op_d    = op_q;
    cnt_d   = cnt_zero ? cnt_q : 16'(cnt_q - 16'h0001);
    paddr_d = paddr_q;
    pdata_d = pdata_q;
    esel_d  = esel_q;
    walk_d  = walk_q;
    case (op_q)
      OP_IDLE, OP_SUSPEND: begin
        if (prog_go) begin
          paddr_d = link.addr;
          pdata_d = wd;
          if (op_q == OP_SUSPEND) begin
            op_d  = OP_SUSP_PROG;
            cnt_d = 16'(PROG_CYC - 1);
          end else if (sector_protect[sect]) begin
            op_d  = OP_PROT_PROG;
            cnt_d = 16'(PSP_CYC - 1);
          end else begin
            op_d  = OP_PROGRAM;
            cnt_d = 16'(PROG_CYC - 1);
          end
        end else if (erase_go) begin
          op_d   = OP_ERASE_WAIT;
          cnt_d  = 16'(WINDOW_CYC - 1);
          esel_d = erase_pick;
        end else if (resume_go) begin
          op_d = OP_ERASE;
        end
      end
      OP_PROGRAM, OP_PROT_PROG: if (cnt_zero) op_d = OP_IDLE;
      OP_SUSP_PROG:             if (cnt_zero) op_d = OP_SUSPEND;
      OP_ERASE_WAIT: begin
        if (erase_go) begin
          cnt_d  = 16'(WINDOW_CYC - 1);
          esel_d = esel_q | erase_pick;
        end else if (cnt_zero && esel_q == '0) begin
          op_d  = OP_PROT_ERASE;
          cnt_d = 16'(ASP_CYC - 1);
        end else if (cnt_zero) begin
          op_d   = OP_ERASE;
          walk_d = '0;
        end
      end
      OP_ERASE: begin
        if (susp_go) begin
          op_d = OP_SUSPEND;
        end else begin
          walk_d = ADDR_W'(walk_q + 1'b1);
          if (walk_last) begin
            op_d   = OP_IDLE;
            esel_d = '0;
          end
        end
      end
      OP_PROT_ERASE: if (cnt_zero) op_d = OP_IDLE;
      default: op_d = OP_IDLE;
    endcase
  end

  // Programming only clears bits, so a 1 over a 0 leaves the 0 behind
  always_ff @(posedge clock) begin
    if ((op_q == OP_PROGRAM || op_q == OP_SUSP_PROG) && cnt_zero)
      mem[paddr_q] <= mem[paddr_q] & pdata_q;
    else if (op_q == OP_ERASE && !susp_go && esel_q[sector_of(walk_q)])
      mem[walk_q] <= 16'hffff;
  end

  // ****************************************************************
  // Status read path
  // ****************************************************************
  wire prog_busy = op_q == OP_PROGRAM || op_q == OP_SUSP_PROG || op_q == OP_PROT_PROG;
  wire erase_busy = op_q == OP_ERASE_WAIT || op_q == OP_ERASE || op_q == OP_PROT_ERASE;
  // Toggles flip once per read cycle, so the host must cycle an enable
  wire tog_run  = prog_busy || erase_busy;
  wire tog_next = tog_q ^ (read_start & tog_run);
  wire etog_run = (op_q == OP_ERASE_WAIT || op_q == OP_ERASE || op_q == OP_SUSPEND) && esel_q[sect];
  wire etog_next = etog_q ^ (read_start & etog_run);
  // Away from the program address the poll bit shows false status
  wire poll_prog = (link.addr == paddr_q) ? ~pdata_q[7] : pdata_q[7];
  wire poll_bit  = prog_busy ? poll_prog : (op_q == OP_SUSPEND);
  wire [15:0] status_word = {8'h00, poll_bit, tog_next, 3'h0, etog_next, 2'h0};
  wire show_array = op_q == OP_IDLE || (op_q == OP_SUSPEND && !esel_q[sect]);
  // All bits switch from status to array in the same cycle
  wire [15:0] rdata_d = show_array ? mem[link.addr] : status_word;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_q     <= CMD_READ;
      op_q      <= OP_IDLE;
      paddr_q   <= '0;
      pdata_q   <= 16'h0000;
      walk_q    <= '0;
      esel_q    <= '0;
      cnt_q     <= 16'h0000;
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      tog_q     <= 1'b0;
      etog_q    <= 1'b0;
      rdata_q   <= 16'h0000;
      busy_q    <= 1'b0;
      bypass_q  <= 1'b0;
    end else begin
      cmd_q     <= cmd_d;
      op_q      <= op_d;
      paddr_q   <= paddr_d;
      pdata_q   <= pdata_d;
      walk_q    <= walk_d;
      esel_q    <= esel_d;
      cnt_q     <= cnt_d;
      wr_prev_q <= ~link.ce_n & ~link.we_n;
      rd_prev_q <= reading;
      tog_q     <= tog_next;
      etog_q    <= etog_next;
      rdata_q   <= reading ? rdata_d : rdata_q;
      busy_q    <= op_d != OP_IDLE && op_d != OP_SUSPEND;
      bypass_q  <= cmd_d != CMD_READ && cmd_d != CMD_UNLOCK1 && cmd_d != CMD_UNLOCK2;
    end
  end

  assign link.rdata  = rdata_q;
  assign busy        = busy_q;
  assign bypass_mode = bypass_q;
  assign op_state    = op_q;
endmodule

// ===== tb/flash_link_sva.sv
// Concurrent checks on the host-to-device flash link
`timescale 1ns/1ns
module flash_link_sva #(
  parameter int ADDR_W = 12
) (
  input logic              clock,
  input logic              resetn,
  input logic              ce_n,
  input logic              oe_n,
  input logic              we_n,
  input logic [ADDR_W-1:0] addr,
  input logic [15:0]       wdata,
  input logic [15:0]       rdata,
  input logic              busy,
  input logic              bypass_mode
);
  logic rd_q;
  logic wr_q;
  wire  rd_st = !ce_n && !oe_n && !rd_q;
  wire  wr_tk = we_n && wr_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      rd_q <= !ce_n && !oe_n;
      wr_q <= !ce_n && !we_n;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ****
  // Sequences and properties
  // ****
  sequence s_pair(logic [15:0] c1, logic [15:0] c2);
    wr_tk && wdata == c1 ##2 wr_tk && wdata == c2;
  endsequence
  sequence s_prog;
    wr_tk && wdata == 16'h00a0 ##2 wr_tk;
  endsequence
  // Poll spacing of three cycles is what the host poll loop produces
  sequence s_polls(logic b);
    b && rd_st ##3 b && rd_st;
  endsequence
  property p_strobe;
    $fell(we_n) |=> we_n;
  endproperty
  property p_hold;
    !$stable(rdata) |-> rd_q;
  endproperty
  property p_quiet;
    busy && !ce_n && !oe_n |=> rdata[15:8] == 8'h00 && rdata[5:3] == 3'h0 && rdata[1:0] == 2'h0;
  endproperty
  property p_toggle;
    s_polls(busy) |=> rdata[6] != $past(rdata[6], 3);
  endproperty
  property p_settled;
    s_polls(!busy) ##0 addr == $past(addr, 3) |=> rdata == $past(rdata, 3);
  endproperty
  property p_enter;
    s_pair(16'h00aa, 16'h0055) ##2 wr_tk && wdata == 16'h0020 |=> ##[0:1] bypass_mode;
  endproperty
  property p_exit;
    bypass_mode && !busy ##0 s_pair(16'h0090, 16'h0000) |=> ##[0:1] !bypass_mode;
  endproperty
  property p_prog;
    bypass_mode && !busy ##0 s_prog |=> ##[0:1] busy;
  endproperty
  property p_refuse;
    !bypass_mode && !busy ##0 s_prog |=> !busy [*2];
  endproperty
  a_strobe: assert property (p_strobe) else $error("write strobe wider than one cycle");
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  a_quiet: assert property (p_quiet) else $error("unused status bits set");
  a_toggle: assert property (p_toggle) else $error("toggle bit did not flip");
  a_settled: assert property (p_settled) else $error("idle reads disagree");
  a_enter: assert property (p_enter) else $error("bypass not entered");
  a_exit: assert property (p_exit) else $error("bypass not left");
  a_prog: assert property (p_prog) else $error("program did not start");
  a_refuse: assert property (p_refuse) else $error("program started outside bypass");
endmodule

// ===== tb/tb.sv
// Self-checking bench: host and device ends joined over the flash link
`timescale 1ns/1ns
module tb;
  import flash_types_pkg::*;
  logic          clock, resetn, req_valid, req_ready, done, busy, bypass_mode;
  host_kind_type req_kind;
  op_state_type  op_state;
  logic [11:0]   req_addr, a;
  logic [15:0]   req_data, result, d;
  logic [7:0]    prot;
  logic [15:0]   exp_q[$], msk_q[$];
  int            n_mismatch, n_compared, cycles;
  flash_link_if i_flash_link_if ();
  flash_status_device #(.PROG_CYC(20), .PSP_CYC(6), .ASP_CYC(6), .WINDOW_CYC(20))
    i_flash_status_device (.clock(clock), .resetn(resetn), .link(i_flash_link_if), .sector_protect(prot),
    .busy(busy), .bypass_mode(bypass_mode), .op_state(op_state));
  flash_status_host i_flash_status_host (.clock(clock), .resetn(resetn), .link(i_flash_link_if),
    .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr), .req_data(req_data),
    .req_ready(req_ready), .done(done), .result(result));
  flash_link_sva i_flash_link_sva (.clock(clock), .resetn(resetn), .ce_n(i_flash_link_if.ce_n),
    .oe_n(i_flash_link_if.oe_n), .we_n(i_flash_link_if.we_n), .addr(i_flash_link_if.addr),
    .wdata(i_flash_link_if.wdata), .rdata(i_flash_link_if.rdata), .busy(busy), .bypass_mode(bypass_mode));
  // ****
  // Tasks
  // ****
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(logic [15:0] seen, logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // Note is queued after the taking edge so the previous done cannot claim it
  task automatic req(host_kind_type k, logic [11:0] ad, logic [15:0] dt, logic [15:0] e = 0, logic [15:0] m = 0);
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= ad;
    req_data <= dt;
    @(posedge clock);
    req_valid <= 1'b0;
    if (m != 16'h0000) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge clock);
    while (done !== 1'b1) @(posedge clock);
  endtask
  // ****
  // Clock, watchdog and result monitor
  // ****
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      conclude();
    end
  end
  always @(posedge clock) begin
    if (done === 1'b1 && exp_q.size() > 0) begin
      chk(result & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    void'($urandom(29518));
    resetn = 1'b0;
    req_valid = 1'b0;
    req_kind = K_READ;
    req_addr = 12'h000;
    req_data = 16'h0000;
    prot = 8'h00;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    req(K_ENTER, 0, 0);
    req(K_CHIP_ERASE, 0, 0);
    req(K_READ, 0, 0, 16'h0000, 16'hffbb);
    req(K_POLL, 0, 0, 16'hffff, 16'hffff);
    $display("test erase done");
    for (int i = 1; i < 4; i++) begin
      a = {i[2:0], 9'($urandom)};
      d = 16'($urandom);
      req(K_PROGRAM, a, d);
      req(K_READ, a, 0, {8'h00, ~d[7], 7'h00}, 16'hffbb);
      req(K_POLL, a, 0, d, 16'hffff);
      req(K_PROGRAM, a, 16'h5a5a);
      req(K_POLL, a, 0, d & 16'h5a5a, 16'hffff);
    end
    $display("test program done");
    a = 12'he05;
    d = 16'($urandom);
    req(K_PROGRAM, a, d);
    req(K_POLL, a, 0, d, 16'hffff);
    prot <= 8'h80;
    req(K_PROGRAM, a, ~d);
    req(K_POLL, a, 0, d, 16'hffff);
    req(K_SECTOR_ERASE, a, 0);
    req(K_SECTOR_ERASE, 12'h200, 0);
    req(K_POLL, 12'h200, 0, 16'hffff, 16'hffff);
    req(K_READ, a, 0, d, 16'hffff);
    req(K_SECTOR_ERASE, a, 0);
    req(K_POLL, a, 0, d, 16'hffff);
    $display("test protect done");
    // Suspend needs the walk running, so let the erase window expire first
    req(K_SECTOR_ERASE, 12'h200, 0);
    repeat (30) @(posedge clock);
    req(K_SUSPEND, 0, 0);
    chk(16'(op_state), 16'(OP_SUSPEND));
    req(K_READ, 12'h200, 0, 16'h0080, 16'hffbb);
    req(K_READ, a, 0, d, 16'hffff);
    req(K_PROGRAM, 12'h8a5, 16'hc3c3);
    req(K_READ, 12'h8a5, 0, 16'h0000, 16'hffbb);
    req(K_POLL, 12'h8a5, 0, 16'hc3c3, 16'hffff);
    req(K_RESUME, 0, 0);
    chk(16'(op_state), 16'(OP_ERASE));
    req(K_POLL, 12'h200, 0, 16'hffff, 16'hffff);
    $display("test suspend done");
    req(K_EXIT, 0, 0);
    req(K_PROGRAM, 12'h200, 16'h1234);
    req(K_READ, 12'h200, 0, 16'hffff, 16'hffff);
    $display("test exit done");
    conclude();
  end
endmodule
